// file: bench/ctrl_host_model.sv
// host model that drives the control pin level
`timescale 1ns/1ns
module ctrl_host_model (
    // clock
    input wire logic core_clk,
    // request from bench
    input wire logic wantOn,
    // pin to device
    output logic ctrlPin
);
    initial ctrlPin = 1'b0;
    // moves only after the falling edge so the device samples a settled level
    always @(negedge core_clk) begin
        ctrlPin <= wantOn;
    end
endmodule

// file: bench/led_boost_protection_sequencer_tb.sv
// self-checking bench for the led boost protection sequencer
`timescale 1ns/1ns
module led_boost_protection_sequencer_tb;
    import led_boost_pkg::*;
    localparam int HalfCyc = 200;
    localparam int OffCyc = 100;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic wantOn = 1'b0;
    logic compTrip = 1'b0;
    logic ctrlPin, switchGate_reg, halfLimit_reg, running_reg, openLedLatched_reg;
    logic [REF_W-1:0] refLevel_reg;
    logic [REF_W-1:0] refSeen;
    fault_in_s faults = '0;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 32'h856A;
    int rises = 0;
    bit randOn = 1'b0;
    always #25 core_clk = ~core_clk;
    always @(posedge switchGate_reg) rises++;
    always @(negedge core_clk) begin
        if (randOn) compTrip <= 1'($random(seed));
    end
    ctrl_host_model u_ctrl_host_model (.core_clk(core_clk), .wantOn(wantOn), .ctrlPin(ctrlPin));
    led_boost_protection_sequencer #(.HalfLimCycles(HalfCyc), .OffCycles(OffCyc))
        u_led_boost_protection_sequencer (.core_clk(core_clk), .reset(reset), .ctrlPin(ctrlPin),
        .faults(faults), .compTrip(compTrip), .switchGate_reg(switchGate_reg),
        .halfLimit_reg(halfLimit_reg), .refLevel_reg(refLevel_reg), .running_reg(running_reg),
        .openLedLatched_reg(openLedLatched_reg));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic int exp_rises(input int n);
        return n / SWITCH_DIV;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // a stall past the bound counts as a mismatch and ends the run
    task automatic wait_run(input logic lvl, input int bound);
        for (int i = 0; i < bound && running_reg !== lvl; i++) begin
            @(negedge core_clk);
        end
        check("running", {7'h00, lvl}, {7'h00, running_reg});
        if (running_reg !== lvl) complete_run();
    endtask
    initial begin
        cyc(12);
        reset <= 1'b0;
        compTrip <= 1'b1;
        cyc(100);
        check("gateRisesOff", 8'h00, rises[7:0]);
        check("halfLimitRst", 8'h01, {7'h00, halfLimit_reg});
        wantOn <= 1'b1;
        wait_run(1'b1, 40);
        check("halfLimitStart", 8'h01, {7'h00, halfLimit_reg});
        rises = 0;
        cyc(160);
        check("gateRises", 8'(exp_rises(160)), rises[7:0]);
        cyc(HalfCyc - 162);
        check("halfLimitHold", 8'h01, {7'h00, halfLimit_reg});
        cyc(1);
        check("halfLimitDrop", 8'h00, {7'h00, halfLimit_reg});
        refSeen = refLevel_reg;
        cyc(STEP_CYC);
        check("refStep", {2'h0, 6'(refSeen + 6'h01)}, {2'h0, refLevel_reg});
        check("halfLimitEnd", 8'h00, {7'h00, halfLimit_reg});
        randOn = 1'b1;
        repeat (3) begin
            wantOn <= 1'b0;
            cyc(10 + ($random(seed) & 63));
            wantOn <= 1'b1;
            cyc(5);
            check("shortLow", 8'h01, {7'h00, running_reg});
        end
        wantOn <= 1'b0;
        wait_run(1'b0, OffCyc + 20);
        wantOn <= 1'b1;
        wait_run(1'b1, 40);
        check("refRestart", 8'h01, {7'h00, refLevel_reg < 6'h02});
        check("halfRestart", 8'h01, {7'h00, halfLimit_reg});
        for (int b = 0; b < 2; b++) begin
            faults <= fault_in_s'(4'h2 >> b);
            wait_run(1'b0, 40);
            rises = 0;
            cyc(64);
            check("gateRisesFault", 8'h00, rises[7:0]);
            faults <= '0;
            wait_run(1'b1, 40);
        end
        faults <= fault_in_s'(4'hC);
        wait_run(1'b0, 8 * SWITCH_DIV + 40);
        check("latched", 8'h01, {7'h00, openLedLatched_reg});
        faults <= '0;
        rises = 0;
        cyc(200);
        check("stayOff", 8'h00, {rises[6:0], running_reg});
        wantOn <= 1'b0;
        cyc(3);
        wantOn <= 1'b1;
        wait_run(1'b1, 40);
        check("unlatched", 8'h00, {7'h00, openLedLatched_reg});
        complete_run();
    end
endmodule

// file: rtl/led_boost_pkg.sv
// constants and carrier types for the led boost protection sequencer
package led_boost_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int SWITCH_HZ = 1_200_000;
    // switching oscillator divider: 20 MHz / 1.2 MHz, rounded down to keep the rate at or above
    localparam int SWITCH_DIV = CLK_HZ / SWITCH_HZ;
    localparam int REF_STEPS = 32;
    localparam int STEP_TIME_US = 213;
    // clock taken in kHz so the products stay inside a 32-bit int
    localparam int STEP_CYC = (STEP_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int HALF_LIM_TIME_US = 5000;
    localparam int HALF_LIM_CYC = (HALF_LIM_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int OFF_TIME_US = 2500;
    localparam int OFF_CYC = (OFF_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int OVP_CYCLES = 8;
    localparam int REF_W = 6;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_LATCHED
    } seq_state_e;

    // analog indications; the open-led pair is sampled per switching cycle, the supply faults every clock
    typedef struct packed {
        logic switchNodeOver;
        logic feedbackLow;
        logic underVoltage;
        logic overTemp;
    } fault_in_s;
endpackage

// file: rtl/led_boost_protection_sequencer.sv
// soft start, protection and shutdown sequencing for a boost led driver
`timescale 1ns/1ns
module led_boost_protection_sequencer
    import led_boost_pkg::*;
#(
    parameter int HalfLimCycles = HALF_LIM_CYC,
    parameter int OffCycles = OFF_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // control pin from host
    input wire logic ctrlPin,
    // analog indications
    input wire fault_in_s faults,
    input wire logic compTrip,
    // outputs to the power stage and status outputs
    output logic switchGate_reg,
    output logic halfLimit_reg,
    output logic [REF_W-1:0] refLevel_reg,
    output logic running_reg,
    output logic openLedLatched_reg
);
    logic [7:0] divCnt_reg;
    logic oscTick;
    logic ctrlPrev_reg;
    logic [$clog2(OffCycles+1)-1:0] lowCnt_reg;
    logic [$clog2(STEP_CYC+1)-1:0] stepCnt_reg;
    logic [$clog2(HalfLimCycles+1)-1:0] halfCnt_reg;
    logic [3:0] ovpCnt_reg;
    logic ovpTrip;
    logic supplyBad;
    logic ctrlOff;
    seq_state_e state_reg;

    assign oscTick = (divCnt_reg == 8'(SWITCH_DIV - 1));
    assign supplyBad = faults.underVoltage | faults.overTemp;
    assign ctrlOff = (lowCnt_reg == ($bits(lowCnt_reg))'(OffCycles));
    assign ovpTrip = oscTick && faults.switchNodeOver && faults.feedbackLow
        && (ovpCnt_reg == 4'(OVP_CYCLES - 1));

    // switching oscillator divider; free running keeps the cycle grid fixed
    always_ff @(posedge core_clk) begin
        if (reset || divCnt_reg == 8'(SWITCH_DIV - 1)) begin
            divCnt_reg <= 8'h00;
        end else begin
            divCnt_reg <= divCnt_reg + 8'h01;
        end
    end

    // control pin low-time measurement
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrlPrev_reg <= 1'b0;
            lowCnt_reg <= '0;
        end else begin
            ctrlPrev_reg <= ctrlPin;
            if (ctrlPin) begin
                lowCnt_reg <= '0;
            end else if (!ctrlOff) begin
                lowCnt_reg <= lowCnt_reg + 1'b1;
            end
        end
    end

    // open-led qualifier, counted once per switching cycle
    always_ff @(posedge core_clk) begin
        if (reset || state_reg != ST_RUN) begin
            ovpCnt_reg <= 4'h0;
        end else if (oscTick) begin
            if (faults.switchNodeOver && faults.feedbackLow) begin
                ovpCnt_reg <= ovpCnt_reg + 4'h1;
            end else begin
                ovpCnt_reg <= 4'h0;
            end
        end
    end

    // top-level sequencing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= ST_OFF;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    // level high enables; a supply fault holds off until it clears
                    if (ctrlPin && !ctrlOff && !supplyBad) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (ctrlOff || supplyBad) begin
                        state_reg <= ST_OFF;
                    end else if (ovpTrip) begin
                        state_reg <= ST_LATCHED;
                    end
                end
                ST_LATCHED: begin
                    // only a high-then-low toggle (falling edge) of the pin releases the latch
                    if (!ctrlPin && ctrlPrev_reg) begin
                        state_reg <= ST_OFF;
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    // soft-start reference ramp and half-limit timer
    always_ff @(posedge core_clk) begin
        if (reset || state_reg != ST_RUN) begin
            stepCnt_reg <= '0;
            refLevel_reg <= '0;
            halfCnt_reg <= '0;
            halfLimit_reg <= 1'b1;
        end else begin
            if (refLevel_reg != (REF_W)'(REF_STEPS)) begin
                if (stepCnt_reg == ($bits(stepCnt_reg))'(STEP_CYC - 1)) begin
                    stepCnt_reg <= '0;
                    refLevel_reg <= refLevel_reg + 1'b1;
                end else begin
                    stepCnt_reg <= stepCnt_reg + 1'b1;
                end
            end
            if (halfCnt_reg == ($bits(halfCnt_reg))'(HalfLimCycles - 1)) begin
                halfLimit_reg <= 1'b0;
            end else begin
                halfCnt_reg <= halfCnt_reg + 1'b1;
            end
        end
    end

    // gate drive: set on oscillator tick, cleared by comparator; forced low when not running
    always_ff @(posedge core_clk) begin
        if (reset || state_reg != ST_RUN || ctrlOff || supplyBad || ovpTrip) begin
            switchGate_reg <= 1'b0;
        end else if (oscTick) begin
            switchGate_reg <= 1'b1;
        end else if (compTrip) begin
            switchGate_reg <= 1'b0;
        end
    end

    // status outputs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            running_reg <= 1'b0;
            openLedLatched_reg <= 1'b0;
        end else begin
            running_reg <= (state_reg == ST_RUN);
            openLedLatched_reg <= (state_reg == ST_LATCHED);
        end
    end

    a_gate_off_down: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg != ST_RUN) |=> !switchGate_reg)
        else $error("switch active while shut down");

    a_latch_holds: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ST_LATCHED && ctrlPin) |=> state_reg == ST_LATCHED)
        else $error("open-led latch released without pin toggle");

    a_ovp_trip: assert property (@(posedge core_clk) disable iff (reset)
        ovpTrip && state_reg == ST_RUN && !ctrlOff && !supplyBad
        |=> state_reg == ST_LATCHED)
        else $error("open-led fault not latched");

    a_ovp_count: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ST_RUN) |-> ovpCnt_reg < 4'(OVP_CYCLES))
        else $error("open-led counter overran");

    a_supply_off: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ST_RUN && supplyBad) |=> state_reg == ST_OFF ##1 !switchGate_reg)
        else $error("supply fault did not shut down");

    a_temp_resume: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ST_OFF && ctrlPin && !ctrlOff && !faults.overTemp && !faults.underVoltage)
        |=> state_reg == ST_RUN)
        else $error("no automatic resume");

    a_ctrl_shutdown: assert property (@(posedge core_clk) disable iff (reset)
        ctrlOff |=> state_reg != ST_RUN)
        else $error("long low on control pin ignored");

    a_ref_reset: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg != ST_RUN) |=> refLevel_reg == '0 && halfLimit_reg)
        else $error("start-up state not cleared in shutdown");

    a_ref_step: assert property (@(posedge core_clk) disable iff (reset)
        $changed(refLevel_reg) && state_reg == ST_RUN && $past(state_reg) == ST_RUN
        |-> refLevel_reg == $past(refLevel_reg) + 1'b1)
        else $error("reference moved by more than one step");

    a_ref_ceiling: assert property (@(posedge core_clk) disable iff (reset)
        refLevel_reg <= (REF_W)'(REF_STEPS))
        else $error("reference beyond target");

    a_half_lim: assert property (@(posedge core_clk) disable iff (reset)
        $fell(halfLimit_reg) |-> halfCnt_reg == ($bits(halfCnt_reg))'(HalfLimCycles - 1))
        else $error("half limit released early");

    a_gate_tick: assert property (@(posedge core_clk) disable iff (reset)
        $rose(switchGate_reg) |-> $past(oscTick))
        else $error("switch turned on off the oscillator grid");

    a_comp_end: assert property (@(posedge core_clk) disable iff (reset)
        switchGate_reg && compTrip && !oscTick |=> !switchGate_reg)
        else $error("comparator trip did not end the on-time");

    a_start_clear: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg != ST_RUN) |=> halfCnt_reg == '0 && stepCnt_reg == '0)
        else $error("start-up counters not cleared in shutdown");
endmodule
